// ### hdl/loader_pkg.sv
package loader_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int REF_CLK_NS = 50;
	localparam int SLOW_CLK_NS = 1000;
	localparam int FAST_CLK_NS = 125;
	localparam int SLOW_HALF_RAW = SLOW_CLK_NS / 2 / REF_CLK_NS;
	localparam int FAST_HALF_RAW = FAST_CLK_NS / 2 / REF_CLK_NS;
	localparam logic [7:0] SLOW_HALF = 8'((SLOW_HALF_RAW < 1) ? 1 : SLOW_HALF_RAW);
	localparam logic [7:0] FAST_HALF = 8'((FAST_HALF_RAW < 1) ? 1 : FAST_HALF_RAW);
	localparam logic [1:0] IO_RELEASE_CLKS = 2'h2;

	// ==========================================================
	// Bitstream fields
	// ==========================================================
	localparam logic [3:0] PREAMBLE = 4'h2;
	localparam logic [3:0] FRAME_CHECK = 4'h6;
	localparam logic [7:0] POSTAMBLE = 8'h7f;
	localparam logic [7:0] X_PREAMBLE = 8'hf2;
	localparam logic [7:0] X_FIELD_CHECK = 8'hd2;
	localparam logic [7:0] X_START = 8'hfe;
	localparam logic [7:0] X_FILL = 8'hff;
	localparam logic [15:0] LEN_END = 16'h0017;
	localparam logic [15:0] FILL_END = 16'h0003;
	localparam logic [15:0] CHECK_END = 16'h0003;
	localparam logic [15:0] LAST_CHECK_END = 16'h000a;
	localparam logic [15:0] POST_END = 16'h0007;
	localparam logic [15:0] X_COUNT_END = 16'h0002;
	localparam int LAST_TAIL = 7;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [3:0] SHIFT_INIT = 4'hf;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum {
		S_WAIT, S_HDR, S_LEN, S_FILL, S_START, S_DATA, S_CHECK, S_POST, S_LOADED,
		S_XHDR, S_XCOUNT, S_XFIELD, S_XSTART, S_XDATA, S_XCHECK, S_XFULL, S_ERROR
	} state_t;

	typedef struct packed {
		logic reprogram_n;
		logic init_line;
		logic done_line;
		logic mode_upper;
		logic mode_lower;
	} pins_t;

	typedef struct packed {
		logic master;
		logic fast;
		logic io_en;
		logic err;
		logic started;
	} xing_t;

	localparam pins_t PINS_RESET = 5'h10;
	localparam xing_t XING_RESET = 5'h00;

endpackage : loader_pkg

// ### hdl/chained_bitstream_loader.sv
`timescale 1ns/10ps
`default_nettype none
module chained_bitstream_loader #(
	parameter int FRAMES = 1077, // Frames per device.
	parameter int DATA_BITS = 302, // Serial data bits per frame.
	parameter int X_DATA_BYTES = 43, // Express data bytes per frame.
	parameter int FAST_BIT_POS = 8 // First-frame data bit that selects the fast rate.
)(
	input wire logic ref_clk, // Reference clock, 20 MHz.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic config_clock, // Configuration clock at the link.
	output logic config_clock_out, // Generated clock in master mode.
	output logic config_clock_oe, // High while the clock pin is driven.
	input wire logic serial_in, // Serial configuration data.
	output logic serial_out, // Serial pass-out or express status.
	input wire logic [7:0] config_byte_bus, // Express byte bus, bit 0 leftmost.
	input wire logic chain_select_high, // Express chain select.
	input wire logic mode_select_upper, // Upper mode pin.
	input wire logic mode_select_lower, // Lower mode pin.
	input wire logic reprogram_n, // Restart request, active low.
	input wire logic init_in, // Level of the initialization line.
	output logic init_out, // Open-drain data, always Low.
	output logic init_oe, // High while the init line is pulled Low.
	input wire logic done_in, // Level of the completion line.
	output logic done_out, // Open-drain data, always Low.
	output logic done_oe, // High while the completion line is pulled Low.
	input wire logic crc_enable, // Frame check uses CRC in serial modes.
	output logic [7:0] frame_data, // Data going to the configuration shift registers.
	output logic frame_data_valid, // Pulse: frame_data holds a new bit or byte.
	output logic user_io_enable, // User I/O released.
	output logic configured, // User I/O released, reference domain.
	output logic load_error, // Frame error seen, reference domain.
	output logic startup_begun // Start-up reached, reference domain.
);

	// ==========================================================
	// Local constants and helpers
	// ==========================================================
	localparam logic [15:0] DATA_END = 16'(DATA_BITS - 1);
	localparam logic [15:0] TAIL_END = 16'(DATA_BITS - 1 - loader_pkg::LAST_TAIL);
	localparam logic [15:0] LAST_FRAME = 16'(FRAMES - 1);
	localparam logic [15:0] X_END = 16'(X_DATA_BYTES - 1);
	localparam logic [15:0] FAST_IDX = 16'(FAST_BIT_POS);

	// Takes a new level once the second and third stages agree.
	function automatic logic [4:0] agree(input logic [4:0] s2, input logic [4:0] s3,
		input logic [4:0] old);
		agree = (s2 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
	endfunction : agree

	// One step of the running CRC over a data bit.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ d) ? loader_pkg::CRC_POLY : 16'h0000);
	endfunction : crc_step

	// Puts bus bit zero at the left of the byte.
	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rev8[7 - i] = b[i];
		end
	endfunction : rev8

	// ==========================================================
	// Link domain synchronisers
	// ==========================================================
	logic lrst_s1, lrst_s2;
	loader_pkg::pins_t lk_s1, lk_s2, lk_s3, lk_pins;
	logic restart;

	// Brings the reset into the link clock domain.
	always_ff @(posedge config_clock) begin
		lrst_s1 <= nrst;
		lrst_s2 <= lrst_s1;
	end

	// Three stages for the pins that are not timed to the link clock.
	always_ff @(posedge config_clock) begin
		lk_s1 <= {reprogram_n, init_in, done_in, mode_select_upper, mode_select_lower};
		lk_s2 <= lk_s1;
		lk_s3 <= lk_s2;
	end

	// Filtered pin levels.
	always_ff @(posedge config_clock) begin
		if (!lrst_s2) begin
			lk_pins <= loader_pkg::PINS_RESET;
		end else begin
			lk_pins <= agree(lk_s2, lk_s3, lk_pins);
		end
	end

	assign restart = !lrst_s2 || !lk_pins.reprogram_n;

	// ==========================================================
	// Bitstream parser
	// ==========================================================
	loader_pkg::state_t state;
	logic [3:0] sh4;
	logic [23:0] len_count;
	logic len_valid;
	logic [15:0] bit_cnt, frame_cnt;
	logic [15:0] crc, chk;
	logic express, master, fast, err;
	logic last_frame;
	logic [15:0] data_end, check_end;
	logic [7:0] xbyte;
	logic [3:0] next_sh4;

	assign last_frame = frame_cnt == LAST_FRAME;
	assign data_end = (crc_enable && last_frame) ? TAIL_END : DATA_END;
	assign check_end = (crc_enable && last_frame) ? loader_pkg::LAST_CHECK_END
		: loader_pkg::CHECK_END;
	assign xbyte = rev8(config_byte_bus);
	assign next_sh4 = {sh4[2:0], serial_in};

	// Walks the header, frames and trailer of one device's data.
	always_ff @(posedge config_clock) begin
		if (restart) begin
			state <= loader_pkg::S_WAIT;
			sh4 <= loader_pkg::SHIFT_INIT;
			len_count <= '0;
			len_valid <= 1'b0;
			bit_cnt <= '0;
			frame_cnt <= '0;
			crc <= loader_pkg::CRC_INIT;
			chk <= '0;
			express <= 1'b0;
			master <= 1'b0;
			fast <= 1'b0;
			err <= 1'b0;
		end else begin
			sh4 <= next_sh4;
			case (state)
				loader_pkg::S_WAIT: begin
					if (lk_pins.init_line) begin
						express <= !lk_pins.mode_upper;
						master <= lk_pins.mode_upper && !lk_pins.mode_lower;
						state <= lk_pins.mode_upper ? loader_pkg::S_HDR : loader_pkg::S_XHDR;
					end
				end
				loader_pkg::S_HDR: begin
					if (next_sh4 == loader_pkg::PREAMBLE) begin
						state <= loader_pkg::S_LEN;
						bit_cnt <= '0;
					end
				end
				loader_pkg::S_LEN: begin
					len_count <= {len_count[22:0], serial_in};
					bit_cnt <= bit_cnt + 16'h0001;
					if (bit_cnt == loader_pkg::LEN_END) begin
						len_valid <= 1'b1;
						bit_cnt <= '0;
						state <= loader_pkg::S_FILL;
					end
				end
				loader_pkg::S_FILL: begin
					bit_cnt <= bit_cnt + 16'h0001;
					if (bit_cnt == loader_pkg::FILL_END) begin
						state <= loader_pkg::S_START;
					end
				end
				loader_pkg::S_START: begin
					if (!serial_in) begin
						bit_cnt <= '0;
						state <= loader_pkg::S_DATA;
					end
				end
				loader_pkg::S_DATA: begin
					crc <= crc_step(crc, serial_in);
					bit_cnt <= bit_cnt + 16'h0001;
					if (master && frame_cnt == 16'h0000 && bit_cnt == FAST_IDX) begin
						fast <= serial_in;
					end
					if (bit_cnt == data_end) begin
						bit_cnt <= '0;
						chk <= crc_enable ? crc_step(crc, serial_in)
							: {loader_pkg::FRAME_CHECK, 12'h000};
						state <= loader_pkg::S_CHECK;
					end
				end
				loader_pkg::S_CHECK: begin
					chk <= {chk[14:0], 1'b0};
					bit_cnt <= bit_cnt + 16'h0001;
					if (serial_in != chk[15]) begin
						err <= 1'b1;
						state <= loader_pkg::S_ERROR;
					end else if (bit_cnt == check_end) begin
						bit_cnt <= '0;
						if (last_frame) begin
							chk <= {loader_pkg::POSTAMBLE, 8'h00};
							state <= loader_pkg::S_POST;
						end else begin
							frame_cnt <= frame_cnt + 16'h0001;
							state <= loader_pkg::S_START;
						end
					end
				end
				loader_pkg::S_POST: begin
					chk <= {chk[14:0], 1'b0};
					bit_cnt <= bit_cnt + 16'h0001;
					if (serial_in != chk[15]) begin
						err <= 1'b1;
						state <= loader_pkg::S_ERROR;
					end else if (bit_cnt == loader_pkg::POST_END) begin
						state <= loader_pkg::S_LOADED;
					end
				end
				loader_pkg::S_XHDR: begin
					if (chain_select_high && xbyte == loader_pkg::X_PREAMBLE) begin
						bit_cnt <= '0;
						state <= loader_pkg::S_XCOUNT;
					end
				end
				loader_pkg::S_XCOUNT: begin
					if (chain_select_high) begin
						bit_cnt <= bit_cnt + 16'h0001;
						if (bit_cnt == loader_pkg::X_COUNT_END) begin
							state <= loader_pkg::S_XFIELD;
						end
					end
				end
				loader_pkg::S_XFIELD: begin
					if (chain_select_high) begin
						if (xbyte == loader_pkg::X_FIELD_CHECK) begin
							state <= loader_pkg::S_XSTART;
						end else begin
							err <= 1'b1;
							state <= loader_pkg::S_ERROR;
						end
					end
				end
				loader_pkg::S_XSTART: begin
					if (chain_select_high) begin
						if (xbyte == loader_pkg::X_START) begin
							bit_cnt <= '0;
							state <= loader_pkg::S_XDATA;
						end else if (xbyte != loader_pkg::X_FILL) begin
							err <= 1'b1;
							state <= loader_pkg::S_ERROR;
						end
					end
				end
				loader_pkg::S_XDATA: begin
					if (chain_select_high) begin
						bit_cnt <= bit_cnt + 16'h0001;
						if (bit_cnt == X_END) begin
							state <= loader_pkg::S_XCHECK;
						end
					end
				end
				loader_pkg::S_XCHECK: begin
					if (chain_select_high) begin
						if (xbyte != loader_pkg::X_FIELD_CHECK) begin
							err <= 1'b1;
							state <= loader_pkg::S_ERROR;
						end else if (last_frame) begin
							state <= loader_pkg::S_XFULL;
						end else begin
							frame_cnt <= frame_cnt + 16'h0001;
							state <= loader_pkg::S_XSTART;
						end
					end
				end
				loader_pkg::S_LOADED, loader_pkg::S_XFULL, loader_pkg::S_ERROR: begin
					state <= state;
				end
				default: begin
					state <= loader_pkg::S_WAIT;
				end
			endcase
		end
	end

	// Hands each data bit or byte to the configuration shift registers.
	always_ff @(posedge config_clock) begin
		if (restart) begin
			frame_data <= '0;
			frame_data_valid <= 1'b0;
		end else begin
			frame_data <= express ? config_byte_bus : {7'h00, serial_in};
			frame_data_valid <= state == loader_pkg::S_DATA
				|| (state == loader_pkg::S_XDATA && chain_select_high);
		end
	end

	// ==========================================================
	// Clock count, start-up and release
	// ==========================================================
	logic [23:0] clk_count;
	logic done_rel;
	logic [1:0] io_cnt;

	// Counts configuration clocks once initialization is over.
	always_ff @(posedge config_clock) begin
		if (restart) begin
			clk_count <= '0;
		end else if (lk_pins.init_line && !done_rel && !express) begin
			clk_count <= clk_count + 24'h00_0001;
		end
	end

	// Releases the completion line and then the user I/O.
	always_ff @(posedge config_clock) begin
		if (restart) begin
			done_rel <= 1'b0;
			io_cnt <= '0;
			user_io_enable <= 1'b0;
		end else if (express) begin
			if (state == loader_pkg::S_XFULL) begin
				done_rel <= 1'b1;
			end
			if (done_rel && lk_pins.done_line) begin
				user_io_enable <= 1'b1;
			end
		end else begin
			if (len_valid && state == loader_pkg::S_LOADED && clk_count == len_count) begin
				done_rel <= 1'b1;
			end
			if (done_rel && !user_io_enable) begin
				io_cnt <= io_cnt + 2'h1;
				if (io_cnt == loader_pkg::IO_RELEASE_CLKS - 2'h1) begin
					user_io_enable <= 1'b1;
				end
			end
		end
	end

	assign done_out = 1'b0;
	assign done_oe = !done_rel;
	assign init_out = 1'b0;
	assign init_oe = err;

	// ==========================================================
	// Pass-out pin
	// ==========================================================
	logic din_q, pass_q, next_serial_out;

	// Captures the sampled bit with whether it may be forwarded.
	always_ff @(posedge config_clock) begin
		if (restart) begin
			din_q <= 1'b1;
			pass_q <= 1'b1;
		end else begin
			din_q <= serial_in;
			pass_q <= state == loader_pkg::S_WAIT || state == loader_pkg::S_HDR
				|| state == loader_pkg::S_LEN
				|| state == loader_pkg::S_LOADED;
		end
	end

	// Express status, Low until full; otherwise the forwarded bit, High while own frames load.
	always_comb begin
		if (express) begin
			next_serial_out = state == loader_pkg::S_XFULL || done_rel;
		end else begin
			next_serial_out = pass_q ? din_q : 1'b1;
		end
	end

	// Pass-out changes on the falling edge.
	always_ff @(negedge config_clock) begin
		if (restart) begin
			serial_out <= 1'b1;
		end else begin
			serial_out <= next_serial_out;
		end
	end

	// ==========================================================
	// Reference domain: status and master clock
	// ==========================================================
	loader_pkg::xing_t rx_s1, rx_s2, rx_s3, rx;
	logic [7:0] div_cnt, half;

	// Three stages for status levels coming from the link domain.
	always_ff @(posedge ref_clk) begin
		rx_s1 <= {master, fast, user_io_enable, err, done_rel};
		rx_s2 <= rx_s1;
		rx_s3 <= rx_s2;
	end

	// Filtered status levels.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx <= loader_pkg::XING_RESET;
		end else begin
			rx <= agree(rx_s2, rx_s3, rx);
		end
	end

	assign configured = rx.io_en;
	assign load_error = rx.err;
	assign startup_begun = rx.started;
	assign half = rx.fast ? loader_pkg::FAST_HALF : loader_pkg::SLOW_HALF;

	// Divides the reference clock down to the master clock.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			div_cnt <= '0;
			config_clock_out <= 1'b0;
			config_clock_oe <= 1'b0;
		end else begin
			config_clock_oe <= rx.master && !rx.io_en;
			if (div_cnt >= half - 8'h01) begin
				div_cnt <= '0;
				config_clock_out <= !config_clock_out;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

endmodule : chained_bitstream_loader
`default_nettype wire

// ### sim/chained_bitstream_loader_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the bitstream loader
// ==========================================================
module loader_checker (
	input wire logic ref_clk, // Reference clock.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic config_clock, // Link clock.
	input wire logic config_clock_oe, // Master clock drive enable.
	input wire logic serial_in, // Serial data in.
	input wire logic serial_out, // Pass-out pin.
	input wire logic chain_select_high, // Express chain select.
	input wire logic mode_select_upper, // Upper mode pin.
	input wire logic init_out, // Init line data.
	input wire logic init_oe, // Init line pull-down enable.
	input wire logic done_in, // Completion line level.
	input wire logic done_out, // Completion line data.
	input wire logic done_oe, // Completion line pull-down enable.
	input wire logic frame_data_valid, // Frame data strobe.
	input wire logic user_io_enable // User I/O released.
);
	// Open-drain pins, release timing, error handling, express status and forwarding.
	property p_pins_low; @(posedge ref_clk) disable iff (!nrst)
		!done_out && !init_out; endproperty
	a_pins_low: assert property (p_pins_low) else $error("open-drain pin data high");
	property p_io_after_done; @(posedge config_clock) disable iff (!nrst)
		$rose(user_io_enable) && !mode_select_upper |-> done_in; endproperty
	a_io_after_done: assert property (p_io_after_done) else $error("io before done");
	property p_io_two; @(posedge config_clock) disable iff (!nrst)
		$fell(done_oe) && mode_select_upper |-> ##1 !user_io_enable ##1 user_io_enable; endproperty
	a_io_two: assert property (p_io_two) else $error("io release not two clocks");
	property p_err_holds; @(posedge config_clock) disable iff (!nrst)
		init_oe |-> done_oe; endproperty
	a_err_holds: assert property (p_err_holds) else $error("done released after error");
	property p_err_quiet; @(posedge config_clock) disable iff (!nrst)
		init_oe && $past(init_oe) |-> !frame_data_valid; endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("data after error");
	property p_x_status; @(posedge config_clock) disable iff (!nrst)
		frame_data_valid && !mode_select_upper |-> !serial_out; endproperty
	a_x_status: assert property (p_x_status) else $error("status high while loading");
	property p_x_select; @(posedge config_clock) disable iff (!nrst)
		(!chain_select_high && !mode_select_upper) [*3] |=> !frame_data_valid; endproperty
	a_x_select: assert property (p_x_select) else $error("data taken unselected");
	property p_fwd; @(posedge config_clock) disable iff (!nrst)
		mode_select_upper && !done_oe && !$past(done_oe) |-> serial_out == $past(serial_in);
	endproperty
	a_fwd: assert property (p_fwd) else $error("pass-out not forwarding");
	property p_no_clk; @(posedge ref_clk) disable iff (!nrst)
		!mode_select_upper |-> !config_clock_oe; endproperty
	a_no_clk: assert property (p_no_clk) else $error("clock driven in express");

	// Main scenarios reached.
	c_serial_done: cover property (@(posedge config_clock) $fell(done_oe) && mode_select_upper);
	c_express_full: cover property (@(posedge config_clock) $rose(serial_out) && !mode_select_upper);
	c_error: cover property (@(posedge config_clock) $rose(init_oe));
endmodule : loader_checker

bind chained_bitstream_loader loader_checker u_chk (
	.ref_clk(ref_clk), .nrst(nrst), .config_clock(config_clock), .config_clock_oe(config_clock_oe),
	.serial_in(serial_in), .serial_out(serial_out), .chain_select_high(chain_select_high),
	.mode_select_upper(mode_select_upper), .init_out(init_out), .init_oe(init_oe),
	.done_in(done_in), .done_out(done_out), .done_oe(done_oe),
	.frame_data_valid(frame_data_valid), .user_io_enable(user_io_enable)
);
`default_nettype wire

// ### sim/bitstream_source.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Configuration source clocking bits or bytes into the loader
// ==========================================================
module bitstream_source (
	output logic src_clk, // Link clock, still between transfers.
	output logic data_bit, // Serial data line.
	output logic [7:0] data_byte, // Express byte bus.
	input wire logic pass_out, // Loader pass-out pin.
	input wire logic [7:0] fdata, // Loader frame data.
	input wire logic fvalid // Loader frame data strobe.
);
	logic so_q[$];
	logic [7:0] fd_q[$];
	int n_rise;

	// Lines start idle with the clock standing still.
	initial begin
		src_clk = 1'b0;
		data_bit = 1'b1;
		data_byte = 8'hff;
		n_rise = 0;
	end

	// One 15 ns cycle: data set while low, loader outputs recorded just before the rise.
	task automatic tick(input logic b, input logic [7:0] v);
		data_bit = b;
		data_byte = v;
		#7.5;
		so_q.push_back(pass_out);
		if (fvalid === 1'b1) fd_q.push_back(fdata);
		src_clk = 1'b1;
		n_rise++;
		#7.5;
		src_clk = 1'b0;
	endtask : tick
endmodule : bitstream_source
`default_nettype wire

// ### sim/chained_bitstream_loader_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Testbench for the bitstream loader
// ==========================================================
module chained_bitstream_loader_tb;
	localparam int LIMIT = 20000;
	localparam logic [23:0] LEN = 24'h00_0078;
	localparam logic [23:0] DBITS = 24'ha5_c3c9;
	localparam logic [7:0] XS [19] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf2, 8'h00,
		8'h00, 8'h03, 8'hd2, 8'hfe, 8'h12, 8'h34, 8'hd2, 8'hfe, 8'h56, 8'h78, 8'hd2};
	logic ref_clk, nrst, use_master, mode_select_upper, mode_select_lower, reprogram_n;
	logic chain_select_high, crc_enable, init_hold, src_clk, data_bit, config_clock_out;
	logic config_clock_oe, serial_out, init_out, init_oe, done_out, done_oe, frame_data_valid;
	logic user_io_enable, configured, load_error, startup_begun, link_clk, init_line, done_line;
	logic [7:0] data_byte, frame_data;
	logic bq[$];
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int n0;

	// Shared link clock and the two open-drain lines with their pull-ups.
	assign link_clk = use_master ? config_clock_out : src_clk;
	assign init_line = init_hold && !(init_oe && !init_out);
	assign done_line = !(done_oe && !done_out);

	chained_bitstream_loader #(.FRAMES(2), .DATA_BITS(12), .X_DATA_BYTES(2), .FAST_BIT_POS(2)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .config_clock(link_clk),
		.config_clock_out(config_clock_out), .config_clock_oe(config_clock_oe),
		.serial_in(data_bit), .serial_out(serial_out), .config_byte_bus(data_byte),
		.chain_select_high(chain_select_high), .mode_select_upper(mode_select_upper),
		.mode_select_lower(mode_select_lower), .reprogram_n(reprogram_n), .init_in(init_line),
		.init_out(init_out), .init_oe(init_oe), .done_in(done_line), .done_out(done_out),
		.done_oe(done_oe), .crc_enable(crc_enable), .frame_data(frame_data),
		.frame_data_valid(frame_data_valid), .user_io_enable(user_io_enable),
		.configured(configured), .load_error(load_error), .startup_begun(startup_begun)
	);

	bitstream_source src (.src_clk(src_clk), .data_bit(data_bit), .data_byte(data_byte),
		.pass_out(serial_out), .fdata(frame_data), .fvalid(frame_data_valid));

	// Reference clock, 50 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Cuts a hung run short.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	function automatic logic [7:0] rev8(input logic [7:0] v);
		return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction : rev8

	task automatic put8(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) bq.push_back(v[i]);
	endtask : put8

	// Resets in the given mode while the source clocks the link, then frees the init line.
	task automatic restart(input logic upper, input logic lower);
		@(posedge ref_clk);
		#2;
		nrst = 1'b0;
		init_hold = 1'b0;
		use_master = 1'b0;
		mode_select_upper = upper;
		mode_select_lower = lower;
		repeat (8) src.tick(1'b1, 8'hff);
		repeat (8) @(posedge ref_clk);
		#2;
		nrst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#2;
		init_hold = 1'b1;
		bq.delete();
		src.so_q.delete();
		src.fd_q.delete();
		src.n_rise = 0;
	endtask : restart

	// Two-frame serial stream, a trailing byte for the next device, then the bits go out.
	task automatic send_serial(input logic [3:0] chk1);
		put8(8'hff);
		put8(8'hff);
		put8({4'h2, LEN[23:20]});
		put8(LEN[19:12]);
		put8(LEN[11:4]);
		put8({LEN[3:0], 4'hf});
		put8(8'hfe);
		put8(DBITS[23:16]);
		put8({DBITS[15:12], chk1});
		put8(8'hfe);
		put8(DBITS[11:4]);
		put8({DBITS[3:0], 4'h6});
		put8(8'h7f);
		put8(8'h4b);
		foreach (bq[k]) src.tick(bq[k], {8{bq[k]}});
	endtask : send_serial

	initial begin
		nrst = 1'b0;
		use_master = 1'b0;
		mode_select_upper = 1'b1;
		mode_select_lower = 1'b1;
		reprogram_n = 1'b1;
		chain_select_high = 1'b1;
		crc_enable = 1'b0;
		init_hold = 1'b0;
		// Serial slave load, start-up after the length count, forwarding to the next device.
		restart(1'b1, 1'b1);
		send_serial(4'h6);
		n0 = 0;
		for (int i = 0; i < 40 && n0 == 0; i++) begin
			src.tick(1'b1, 8'hff);
			if (done_oe === 1'b0) n0 = src.n_rise;
		end
		check(32'(n0 >= LEN + 2 && n0 <= LEN + 9), 32'h1);
		for (int i = 0; i < 8 && user_io_enable !== 1'b1; i++) src.tick(1'b1, 8'hff);
		check(32'(src.n_rise - n0), 32'h2);
		for (int k = 0; k < 112; k++) begin
			check(32'(src.so_q[k + 1]), 32'((k >= 44 && k < 104) ? 1'b1 : bq[k]));
		end
		check(32'(src.fd_q.size()), 32'h18);
		for (int i = 0; i < 24; i++) check(32'(src.fd_q[i][0]), 32'(DBITS[23 - i]));
		repeat (10) @(posedge ref_clk);
		#2;
		check({29'h0, configured, startup_begun, load_error}, 32'h6);
		// Wrong constant check in frame one, then a restart through the reprogram input.
		restart(1'b1, 1'b1);
		send_serial(4'h7);
		repeat (10) @(posedge ref_clk);
		#2;
		check({28'h0, init_oe, done_oe, user_io_enable, load_error}, 32'hd);
		check(32'(src.fd_q.size() <= 12), 32'h1);
		reprogram_n = 1'b0;
		repeat (6) src.tick(1'b1, 8'hff);
		reprogram_n = 1'b1;
		repeat (6) src.tick(1'b1, 8'hff);
		check(32'(init_oe), 32'h0);
		// Express load: first unselected, then selected with the check input set.
		restart(1'b0, 1'b1);
		crc_enable = 1'b1;
		chain_select_high = 1'b0;
		for (int i = 0; i < 19; i++) src.tick(1'b1, rev8(XS[i]));
		check(32'(src.fd_q.size()), 32'h0);
		chain_select_high = 1'b1;
		src.so_q.delete();
		for (int i = 0; i < 19; i++) src.tick(1'b1, rev8(XS[i]));
		check({30'h0, src.so_q[15], src.so_q[18]}, 32'h0);
		// Pass-out moves on the falling edge that the last tick has only just made.
		#1;
		check(32'(serial_out), 32'h1);
		for (int i = 0; i < 12 && user_io_enable !== 1'b1; i++) src.tick(1'b1, 8'hff);
		check({30'h0, done_oe, user_io_enable}, 32'h1);
		check(32'(src.fd_q.size()), 32'h4);
		// Bytes reach the shift registers exactly as driven on the bus.
		check({src.fd_q[0], src.fd_q[1], src.fd_q[2], src.fd_q[3]}, 32'h482c_6a1e);
		crc_enable = 1'b0;
		// Master mode drives its own slow clock.
		restart(1'b1, 1'b0);
		repeat (8) src.tick(1'b1, 8'hff);
		use_master = 1'b1;
		for (int i = 0; i < 400 && config_clock_oe !== 1'b1; i++) @(posedge ref_clk);
		check(32'(config_clock_oe), 32'h1);
		@(posedge config_clock_out);
		n0 = cycles;
		@(posedge config_clock_out);
		check(32'(cycles - n0), 32'(2 * loader_pkg::SLOW_HALF));
		tally_and_finish();
	end
endmodule : chained_bitstream_loader_tb
`default_nettype wire
